/* File: src/otc_top.v */
// offset calibration sequencing and trim application for a two-core interleaved converter
// assumes all inputs synchronous to core_clk; offset results come from the calibration engine
`timescale 1ns/1ps
`include "otc_defs.vh"

// How it works
// - foreground offset enable: offsets corrected once during the foreground pass
// - background offset enable: offsets corrected repeatedly during background running
// - foreground enable latched at calibration start gives one-time offset under background
// - calibration results land in offset trims; software writes blocked while in use
// - foreground offset with background select calibrates all three cores
// - dual mode: channel A from core A input A, channel B from core B input B
// - 0 deg bank timing for dual and core B single; -90 deg for core A single
// - dual mode: either inter-core trim shifts core A against core B
// - single mode: dedicated single-channel timing trims set core A against core B
// - foreground start from pin or software trigger, chosen by pin trigger select
module otc_top #(
	parameter W = `OTC_TRIM_W
) (
	input  wire         core_clk,
	input  wire         rst,
	input  wire         fg_offset_cal_enable,
	input  wire         bg_offset_cal_enable,
	input  wire         background_calibration_select,
	input  wire         pin_trigger_select,
	input  wire         software_cal_trigger,
	input  wire         cal_trigger_pin,
	input  wire         single_channel_mode,
	input  wire         offset_trim_we,
	input  wire [1:0]   offset_trim_sel,
	input  wire [W-1:0] offset_trim_wdata,
	input  wire         offset_result_valid,
	input  wire [W-1:0] offset_result,
	output reg          foreground_complete_flag,
	output reg          cal_busy,
	output reg          offset_cal_active,
	output reg  [1:0]   offset_cal_core,
	output reg          offset_step_req,
	output reg          offset_write_refused,
	output reg          offset_trims_readable,
	output reg  [W-1:0] ofs_a_vina,
	output reg  [W-1:0] ofs_a_vinb,
	output reg  [W-1:0] ofs_b_vina,
	output reg  [W-1:0] ofs_b_vinb,
	output reg  [W-1:0] channel_a_offset,
	output reg  [W-1:0] channel_b_offset,
	input  wire [W-1:0] bank_timing_trim_0deg,
	input  wire [W-1:0] bank_timing_trim_m90,
	input  wire [W-1:0] core_a_timing_trim_dual,
	input  wire [W-1:0] core_b_timing_trim_dual,
	input  wire [W-1:0] core_a_timing_trim_single,
	input  wire [W-1:0] core_b_timing_trim_single,
	output reg  [W-1:0] core_a_bank_timing,
	output reg  [W-1:0] core_b_bank_timing,
	output reg  [W-1:0] core_a_intercore_timing,
	output reg  [W-1:0] core_b_intercore_timing
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [2:0] ST_POWERUP = 3'd0;
	localparam [2:0] ST_IDLE    = 3'd1;
	localparam [2:0] ST_OFS     = 3'd2;
	localparam [2:0] ST_WAIT    = 3'd3;
	localparam [2:0] ST_DONE    = 3'd4;
	localparam [2:0] ST_BG      = 3'd5;
	localparam [2:0] ST_BG_GAP  = 3'd6;
	localparam [15:0] STEP_CYC  = `OTC_STEP_CYC;
	localparam [15:0] GAP_CYC   = `OTC_BG_GAP_CYC;

	reg  [2:0]  state;
	reg  [15:0] timer;
	reg         trig_prev;
	reg         os_latched;
	reg         bgos_latched;
	reg         bg_latched;
	reg  [1:0]  last_core;

	// ----------------------------------------
	// trigger source
	// ----------------------------------------
	wire trig_level = pin_trigger_select ? cal_trigger_pin : software_cal_trigger;
	wire trig_rise  = trig_level & ~trig_prev;
	// background running needs software trigger high with pin source off
	wire bg_run     = background_calibration_select & ~pin_trigger_select & software_cal_trigger;

	always @(posedge core_clk) begin
		if (rst)
			trig_prev <= 1'b0;
		else
			trig_prev <= trig_level;
	end

	// ----------------------------------------
	// offset calibration sequencer
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rst) begin
			state                    <= ST_POWERUP;
			timer                    <= 16'h0000;
			os_latched               <= 1'b0;
			bgos_latched             <= 1'b0;
			bg_latched               <= 1'b0;
			last_core                <= 2'd0;
			offset_cal_core          <= 2'd0;
			offset_step_req          <= 1'b0;
			foreground_complete_flag <= 1'b0;
			cal_busy                 <= 1'b0;
			offset_cal_active        <= 1'b0;
		end else begin
			offset_step_req <= 1'b0;
			case (state)
			ST_POWERUP: begin
				// power-on foreground pass, captures enables at start
				os_latched   <= fg_offset_cal_enable;
				bgos_latched <= bg_offset_cal_enable;
				bg_latched   <= background_calibration_select;
				cal_busy     <= 1'b1;
				state        <= ST_OFS;
			end
			ST_IDLE: begin
				if (trig_rise) begin
					// edge only: a held background trigger must not restart passes
					// enable must already be set when the trigger arrives
					os_latched               <= fg_offset_cal_enable;
					bgos_latched             <= bg_offset_cal_enable;
					bg_latched               <= background_calibration_select;
					foreground_complete_flag <= 1'b0;
					cal_busy                 <= 1'b1;
					state                    <= ST_OFS;
				end
			end
			ST_OFS: begin
				if (os_latched) begin
					// one pass over the cores; three with the spare under background
					offset_cal_active <= 1'b1;
					offset_cal_core   <= 2'd0;
					last_core         <= bg_latched ? `OTC_CORE_SPARE : `OTC_CORE_B;
					offset_step_req   <= 1'b1;
					timer             <= STEP_CYC;
					state             <= ST_WAIT;
				end else
					state <= ST_DONE;
			end
			ST_WAIT: begin
				if (timer != 16'h0000)
					timer <= timer - 16'h0001;
				if (offset_result_valid | (timer == 16'h0000)) begin
					if (offset_cal_core == last_core)
						state <= ST_DONE;
					else begin
						offset_cal_core <= offset_cal_core + 2'd1;
						offset_step_req <= 1'b1;
						timer           <= STEP_CYC;
					end
				end
			end
			ST_DONE: begin
				offset_cal_active        <= 1'b0;
				foreground_complete_flag <= 1'b1;
				cal_busy                 <= 1'b0;
				timer                    <= GAP_CYC;
				state                    <= (bg_latched & bgos_latched) ? ST_BG_GAP : ST_IDLE;
			end
			ST_BG_GAP: begin
				if (~bg_run) begin
					offset_cal_active <= 1'b0;
					state             <= ST_IDLE;
				end else if (timer == 16'h0000)
					state <= ST_BG;
				else
					timer <= timer - 16'h0001;
			end
			ST_BG: begin
				// background repeats offset steps while enabled
				if (~bg_run | ~bg_offset_cal_enable) begin
					offset_cal_active <= 1'b0;
					state             <= ST_IDLE;
				end else begin
					offset_cal_active <= 1'b1;
					offset_cal_core   <= (offset_cal_core == `OTC_CORE_SPARE) ? 2'd0 : offset_cal_core + 2'd1;
					offset_step_req   <= 1'b1;
					timer             <= GAP_CYC;
					state             <= ST_BG_GAP;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// offset trim registers
	// ----------------------------------------
	wire        ofs_in_use = os_latched | bgos_latched | offset_cal_active;
	wire        sw_ok      = offset_trim_we & ~ofs_in_use;
	wire        cal_ld     = offset_cal_active & offset_result_valid;
	wire [3:0]  sw_dec     = 4'b0001 << offset_trim_sel;
	// spare core results land in the core A slots
	wire [3:0]  cal_dec    = (offset_cal_core == `OTC_CORE_B) ? 4'b1100 : 4'b0011;
	wire [4*W-1:0] trim_q;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_ofs
			// index bit 1 is core, bit 0 is input
			otc_trim_reg #(
				.W       (W),
				.RST_VAL (`OTC_OFS_RST)
			) u_ofs (
				.core_clk (core_clk),
				.rst      (rst),
				.sw_we    (sw_ok & sw_dec[g]),
				.sw_data  (offset_trim_wdata),
				.cal_we   (cal_ld & cal_dec[g]),
				.cal_data (offset_result),
				.value    (trim_q[g*W +: W])
			);
		end
	endgenerate

	// ----------------------------------------
	// applied trims
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rst) begin
			offset_write_refused    <= 1'b0;
			offset_trims_readable   <= 1'b0;
			ofs_a_vina              <= `OTC_OFS_RST;
			ofs_a_vinb              <= `OTC_OFS_RST;
			ofs_b_vina              <= `OTC_OFS_RST;
			ofs_b_vinb              <= `OTC_OFS_RST;
			channel_a_offset        <= `OTC_OFS_RST;
			channel_b_offset        <= `OTC_OFS_RST;
			core_a_bank_timing      <= `OTC_TIME_RST;
			core_b_bank_timing      <= `OTC_TIME_RST;
			core_a_intercore_timing <= `OTC_TIME_RST;
			core_b_intercore_timing <= `OTC_TIME_RST;
		end else begin
			offset_write_refused  <= offset_trim_we & ofs_in_use;
			offset_trims_readable <= foreground_complete_flag & ~bgos_latched & ~offset_cal_active;
			ofs_a_vina            <= trim_q[0*W +: W];
			ofs_a_vinb            <= trim_q[1*W +: W];
			ofs_b_vina            <= trim_q[2*W +: W];
			ofs_b_vinb            <= trim_q[3*W +: W];
			channel_a_offset      <= trim_q[0*W +: W];
			channel_b_offset      <= trim_q[3*W +: W];
			core_a_bank_timing    <= single_channel_mode ? bank_timing_trim_m90 : bank_timing_trim_0deg;
			core_b_bank_timing    <= bank_timing_trim_0deg;
			core_a_intercore_timing <= single_channel_mode ? core_a_timing_trim_single
			                                               : core_a_timing_trim_dual;
			core_b_intercore_timing <= single_channel_mode ? core_b_timing_trim_single
			                                               : core_b_timing_trim_dual;
		end
	end
endmodule // otc_top

/* File: src/otc_defs.vh */
// constants for the offset calibration and trim control block
// assumes inclusion by bare name from the design files
`ifndef OTC_DEFS_VH
`define OTC_DEFS_VH

// ----------------------------------------
// trim widths and reset values
// ----------------------------------------
`define OTC_TRIM_W        8
`define OTC_OFS_RST       8'h80
`define OTC_GAIN_RST      8'h80
`define OTC_TIME_RST      8'h80

// ----------------------------------------
// sequencer timing
// ----------------------------------------
`define OTC_CLK_MHZ       200
`define OTC_STEP_NS       100
// 100 ns step at 200 MHz, rounded up
`define OTC_STEP_CYC      16'd20
`define OTC_BG_GAP_CYC    16'd64

// ----------------------------------------
// core indices
// ----------------------------------------
`define OTC_CORE_A        2'd0
`define OTC_CORE_B        2'd1
`define OTC_CORE_SPARE    2'd2
`define OTC_NUM_CORES     3

`endif

/* File: src/otc_trim_reg.v */
// one trim register: software write or calibration load, value held otherwise
// assumes synchronous active-high reset on core_clk
`timescale 1ns/1ps
module otc_trim_reg #(
	parameter W = 8,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input  wire         core_clk,
	input  wire         rst,
	input  wire         sw_we,
	input  wire [W-1:0] sw_data,
	input  wire         cal_we,
	input  wire [W-1:0] cal_data,
	output reg  [W-1:0] value
);
	// calibration load wins over a software write
	always @(posedge core_clk) begin
		if (rst)
			value <= RST_VAL;
		else if (cal_we)
			value <= cal_data;
		else if (sw_we)
			value <= sw_data;
	end
endmodule // otc_trim_reg

/* File: tb/otc_top_assertions.sv */
// port checker for otc_top
// assumes bind onto otc_top, one clock core_clk, sync reset rst
`timescale 1ns/1ps
module otc_top_chk #(
	parameter W = 8
) (
	input wire logic		core_clk,
	input wire logic		rst,
	input wire logic		single_channel_mode,
	input wire logic [W-1:0]	bank_timing_trim_0deg,
	input wire logic [W-1:0]	bank_timing_trim_m90,
	input wire logic [W-1:0]	core_a_bank_timing,
	input wire logic [W-1:0]	core_b_bank_timing,
	input wire logic [W-1:0]	ofs_a_vina,
	input wire logic [W-1:0]	channel_a_offset,
	input wire logic		offset_trim_we,
	input wire logic		offset_result_valid,
	input wire logic		offset_write_refused,
	input wire logic		offset_cal_active,
	input wire logic		offset_step_req,
	input wire logic [1:0]		offset_cal_core,
	input wire logic		foreground_complete_flag,
	input wire logic		cal_busy
);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_chan_a_map: assert property ($stable(ofs_a_vina) |-> channel_a_offset == ofs_a_vina)
		else $error("channel a offset wrong");
	chk_bank_a_sel: assert property (!$past(rst) |-> core_a_bank_timing == ($past(single_channel_mode)
		? $past(bank_timing_trim_m90) : $past(bank_timing_trim_0deg)))
		else $error("core a bank timing wrong");
	chk_bank_b_sel: assert property ($stable(bank_timing_trim_0deg) |=>
		core_b_bank_timing == $past(bank_timing_trim_0deg))
		else $error("core b bank timing wrong");
	chk_refuse_cause: assert property (offset_write_refused |-> $past(offset_trim_we))
		else $error("refusal without write");
	chk_refuse_active: assert property (offset_trim_we && offset_cal_active |=> offset_write_refused)
		else $error("write during calibration not refused");
	chk_done_end: assert property ($rose(foreground_complete_flag) |-> $past(cal_busy) && !cal_busy)
		else $error("complete flag outside pass end");
	chk_step_core: assert property (offset_step_req |-> offset_cal_active && offset_cal_core <= 2'h2)
		else $error("offset step outside pass");
	chk_trim_hold: assert property ((!offset_trim_we && !offset_result_valid) [*3] |=> $stable(ofs_a_vina))
		else $error("trim changed without cause");
endmodule // otc_top_chk

bind otc_top otc_top_chk #(.W(W)) u_otc_chk (.*);

/* File: tb/tb_otc_top.sv */
// self-checking bench for otc_top
// assumes otc_top and its checker are compiled first
`timescale 1ns/1ps
module tb_otc_top;
	logic		core_clk = 0, rst = 1, fg_offset_cal_enable = 0, bg_offset_cal_enable = 0;
	logic		background_calibration_select = 0, pin_trigger_select = 0, software_cal_trigger = 0;
	logic		cal_trigger_pin = 0, single_channel_mode = 0, offset_trim_we = 0, offset_result_valid = 0;
	logic [1:0]	offset_trim_sel = 0, offset_cal_core;
	logic [7:0]	offset_trim_wdata = 0, offset_result = 0, bank_timing_trim_0deg = 0, bank_timing_trim_m90 = 0;
	logic [7:0]	core_a_timing_trim_dual = 0, core_b_timing_trim_dual = 0, core_a_timing_trim_single = 0;
	logic [7:0]	core_b_timing_trim_single = 0, ofs_a_vina, ofs_a_vinb, ofs_b_vina, ofs_b_vinb;
	logic [7:0]	channel_a_offset, channel_b_offset, core_a_bank_timing, core_b_bank_timing;
	logic [7:0]	core_a_intercore_timing, core_b_intercore_timing;
	logic		foreground_complete_flag, cal_busy, offset_cal_active, offset_step_req;
	logic		offset_write_refused, offset_trims_readable;
	int		mismatches = 0, checks_done = 0, cycles = 0;

	otc_top DUT (.*);

	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			finish_test();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task cmp(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [1:0] s, input logic [7:0] d);
		offset_trim_we <= 1'b1;
		offset_trim_sel <= s;
		offset_trim_wdata <= d;
		tick(1);
		offset_trim_we <= 1'b0;
		tick(1);
	endtask
	task t_reset;
		int k;
		k = 0;
		while (foreground_complete_flag !== 1'b1 && k < 100) begin
			tick(1);
			k++;
		end
		cmp({cal_busy, ofs_a_vina, ofs_a_vinb, ofs_b_vina, ofs_b_vinb}, {1'b0, {4{8'h80}}});
		$display("reset test done");
	endtask
	task t_timing;
		bank_timing_trim_0deg <= 8'h11;
		bank_timing_trim_m90 <= 8'h22;
		core_a_timing_trim_dual <= 8'h33;
		core_b_timing_trim_dual <= 8'h44;
		core_a_timing_trim_single <= 8'h55;
		core_b_timing_trim_single <= 8'h66;
		for (int m = 0; m < 2; m++) begin
			single_channel_mode <= m[0];
			tick(3);
			cmp({core_a_bank_timing, core_b_bank_timing}, m ? 16'h2211 : 16'h1111);
			cmp({core_a_intercore_timing, core_b_intercore_timing}, m ? 16'h5566 : 16'h3344);
		end
		single_channel_mode <= 1'b0;
		$display("timing test done");
	endtask
	// gain, full-scale and termination trims are not ports here; bench leaves them alone
	task t_write;
		for (int s = 0; s < 4; s++)
			wr(s[1:0], 8'h40 + s[7:0]);
		tick(1);
		cmp({ofs_a_vina, ofs_a_vinb, ofs_b_vina, ofs_b_vinb}, 32'h40414243);
		cmp({channel_a_offset, channel_b_offset}, 16'h4043);
		single_channel_mode <= 1'b1;
		wr(2'h0, 8'h50);
		wr(2'h2, 8'h50);
		tick(1);
		cmp({ofs_a_vina, ofs_b_vina, channel_a_offset}, 24'h505050);
		single_channel_mode <= 1'b0;
		$display("write test done");
	endtask
	task run_pass(input int n, input bit viapin);
		int k;
		if (viapin)
			cal_trigger_pin <= 1'b1;
		else
			software_cal_trigger <= 1'b1;
		for (int i = 0; i < n; i++) begin
			k = 0;
			while (offset_step_req !== 1'b1 && k < 100) begin
				tick(1);
				k++;
			end
			cmp({offset_step_req, offset_cal_core}, {1'b1, i[1:0]});
			if (i == 0) begin
				wr(2'h0, 8'h33);
				cmp(offset_write_refused, 1'b1);
			end
			offset_result_valid <= 1'b1;
			offset_result <= 8'h20 + i[7:0];
			tick(1);
			offset_result_valid <= 1'b0;
		end
		k = 0;
		while (foreground_complete_flag !== 1'b1 && k < 100) begin
			tick(1);
			k++;
		end
		cmp({foreground_complete_flag, cal_busy}, 2'b10);
		cal_trigger_pin <= 1'b0;
		software_cal_trigger <= 1'b0;
		tick(2);
	endtask
	task t_fg;
		fg_offset_cal_enable <= 1'b1;
		run_pass(2, 1'b0);
		cmp(offset_trims_readable, 1'b1);
		cmp({ofs_a_vina, ofs_a_vinb, ofs_b_vina, ofs_b_vinb}, 32'h20202121);
		background_calibration_select <= 1'b1;
		pin_trigger_select <= 1'b1;
		software_cal_trigger <= 1'b1;
		tick(4);
		cmp(cal_busy, 1'b0);
		run_pass(3, 1'b1);
		cmp({ofs_a_vina, ofs_a_vinb, ofs_b_vina, ofs_b_vinb}, 32'h22222121);
		$display("foreground test done");
	endtask
	task t_bg;
		int c;
		c = 0;
		fg_offset_cal_enable <= 1'b0;
		pin_trigger_select <= 1'b0;
		bg_offset_cal_enable <= 1'b1;
		tick(1);
		software_cal_trigger <= 1'b1;
		repeat (300) begin
			tick(1);
			c += (offset_step_req === 1'b1);
		end
		cmp(c >= 2, 1'b1);
		cmp(offset_trims_readable, 1'b0);
		wr(2'h3, 8'h55);
		cmp(offset_write_refused, 1'b1);
		$display("background test done");
	endtask
	task finish_test;
		$display("checks=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		tick(12);
		rst <= 1'b0;
		t_reset();
		t_timing();
		t_write();
		t_fg();
		t_bg();
		finish_test();
	end
endmodule // tb_otc_top
